/* logic/acd_top.sv */
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
// aux clock divider control block with apb register access
module acd_top (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic sys_rst_b_i,
  input wire logic [31:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic aux_osc_tick_i,
  input wire logic pll_tick_i,
  output logic [1:0] aux_oscillator_mode_o,
  output logic aux_reference_source_select_o,
  output logic aux_divider_source_select_o,
  output logic aux_div_tick_o
);

  // control register fields, power-on reset only
  logic src_sel_r; // divider source select
  logic [1:0] osc_mode_r; // oscillator mode
  logic [2:0] ratio_r; // post-divide code
  logic ref_sel_r; // reference source select

  // apb handshake state
  logic pready_r; // one wait state then ready
  logic [31:0] prdata_r; // read data
  logic pslverr_r; // unmapped access error, high only in the ready cycle

  // registered pin outputs
  logic div_tick_r; // divided pulse to pin

  // access decode
  logic acc_go; // access phase completing this edge
  logic hit_ctrl; // control offset hit
  logic hit_stat; // status offset hit
  logic mapped; // any mapped offset
  logic [15:0] ctrl_word; // assembled control word
  logic [15:0] stat_word; // assembled status word
  logic [15:0] wr_word; // write data after byte lanes

  acd_clk_if cif ();

  // drive the interface from the control fields, the system reset and the tick inputs
  assign cif.src_sel = src_sel_r;
  assign cif.osc_mode = osc_mode_r;
  assign cif.ratio = ratio_r;
  assign cif.sys_rst_b = sys_rst_b_i;
  assign cif.aux_tick = aux_osc_tick_i;
  assign cif.pll_tick = pll_tick_i;

  acd_src_mux u_mux (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .cif(cif)
  );

  acd_post_div u_div (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .cif(cif)
  );

  // address decode on the low address bits
  assign hit_ctrl = (paddr_i[11:0] == acd_pkg::ACD_CTRL_OFF);
  assign hit_stat = (paddr_i[11:0] == acd_pkg::ACD_STAT_OFF);
  assign mapped = hit_ctrl || hit_stat;
  assign acc_go = psel_i && penable_i && pready_r;

  // control word as read back, unused bits zero
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[acd_pkg::ACD_SRC_BIT] = src_sel_r;
    ctrl_word[acd_pkg::ACD_MODE_LSB +: 2] = osc_mode_r;
    ctrl_word[acd_pkg::ACD_RATIO_LSB +: 3] = ratio_r;
    ctrl_word[acd_pkg::ACD_REF_BIT] = ref_sel_r;
  end

  // status word shows running state and output pulse count
  always_comb begin
    stat_word = 16'h0000;
    stat_word[acd_pkg::ACD_ST_RUN_BIT] = (osc_mode_r != acd_pkg::ACD_MODE_OFF);
    stat_word[acd_pkg::ACD_ST_SRC_BIT] = src_sel_r;
    stat_word[acd_pkg::ACD_ST_CNT_LSB +: 8] = cif.div_cnt;
  end

  // merge write data by byte lane over the old control word
  always_comb begin
    wr_word = ctrl_word;
    if (pstrb_i[0]) begin
      wr_word[7:0] = pwdata_i[7:0];
    end
    if (pstrb_i[1]) begin
      wr_word[15:8] = pwdata_i[15:8];
    end
    wr_word = wr_word & acd_pkg::ACD_CTRL_MASK;
  end

  // apb ready: one wait state on every access
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_r <= 1'b0;
    end else if (psel_i && penable_i && !pready_r) begin
      pready_r <= 1'b1;
    end else begin
      pready_r <= 1'b0;
    end
  end

  // read data and error, set ahead of the ready cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel_i && penable_i && !pready_r) begin
      pslverr_r <= !mapped;
      if (!pwrite_i && hit_ctrl) begin
        prdata_r <= {16'h0000, ctrl_word};
      end else if (!pwrite_i && hit_stat) begin
        prdata_r <= {16'h0000, stat_word};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end else begin
      // error stands for the ready cycle only, so the pin needs no gating
      pslverr_r <= 1'b0;
    end
  end

  // control register, cleared only by power-on reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_sel_r <= acd_pkg::ACD_SRC_RST;
      osc_mode_r <= acd_pkg::ACD_MODE_RST;
      ratio_r <= acd_pkg::ACD_RATIO_RST;
      ref_sel_r <= acd_pkg::ACD_REF_RST;
    end else if (acc_go && pwrite_i && hit_ctrl) begin
      // system reset is ignored here on purpose
      src_sel_r <= wr_word[acd_pkg::ACD_SRC_BIT];
      osc_mode_r <= wr_word[acd_pkg::ACD_MODE_LSB +: 2];
      ratio_r <= wr_word[acd_pkg::ACD_RATIO_LSB +: 3];
      ref_sel_r <= wr_word[acd_pkg::ACD_REF_BIT];
    end
  end

  // divided pulse retimed to the pin
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_tick_r <= 1'b0;
    end else begin
      div_tick_r <= cif.div_tick;
    end
  end

  // outputs straight from flops
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign aux_oscillator_mode_o = osc_mode_r;
  assign aux_reference_source_select_o = ref_sel_r;
  assign aux_divider_source_select_o = src_sel_r;
  assign aux_div_tick_o = div_tick_r;

  // pll source: each pll pulse outside system reset reaches the divider one edge later
  AST_PLL_ROUTE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!src_sel_r && sys_rst_b_i && pll_tick_i && $stable(src_sel_r)) |=> cif.sel_tick)
    else $error("pll pulse not routed");

  // aux source with oscillator on passes aux pulses
  AST_AUX_ROUTE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (src_sel_r && osc_mode_r != acd_pkg::ACD_MODE_OFF && sys_rst_b_i && aux_osc_tick_i)
      |=> cif.sel_tick)
    else $error("aux pulse not routed");

  // mode field follows a control write one edge later
  AST_MODE_WRITE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (acc_go && pwrite_i && hit_ctrl && pstrb_i[1])
      |=> aux_oscillator_mode_o == $past(pwdata_i[12:11]))
    else $error("mode field not written");

  // ratio field follows a control write
  AST_RATIO_WRITE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (acc_go && pwrite_i && hit_ctrl && pstrb_i[1]) |=> ratio_r == $past(pwdata_i[10:8]))
    else $error("ratio field not written");

  // system reset leaves the control word untouched
  AST_SYSRST_KEEP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!sys_rst_b_i && !(acc_go && pwrite_i && hit_ctrl)) |=> $stable(ctrl_word))
    else $error("control word changed by system reset");

  // reference bit written and unused bits read zero
  AST_REF_WRITE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (acc_go && pwrite_i && hit_ctrl && pstrb_i[0])
      |=> aux_reference_source_select_o == $past(pwdata_i[7]))
    else $error("reference bit not written");

  AST_UNUSED_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (pready_r && !pwrite_i && hit_ctrl && psel_i)
      |-> (prdata_o & ~{16'h0000, acd_pkg::ACD_CTRL_MASK}) == 32'h0000_0000)
    else $error("unused control bits read nonzero");

  // ready comes exactly one edge after the access phase opens
  AST_READY_ONE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (psel_i && penable_i && !pready_r) |=> pready_r ##1 !pready_r)
    else $error("ready timing broken");

endmodule : acd_top

/* logic/acd_pkg.sv */
// Behaviour
// - bit 13 picks aux oscillator or PLL
// - two-bit oscillator mode, 00 off default
// - three-bit post-divide, 111 /1 to 000 /256
// - only power-on reset restores control register
package acd_pkg;

  // register byte offsets
  localparam logic [11:0] ACD_CTRL_OFF = 12'h000;
  localparam logic [11:0] ACD_STAT_OFF = 12'h004;

  // control field positions
  localparam int ACD_SRC_BIT = 13;
  localparam int ACD_MODE_LSB = 11;
  localparam int ACD_RATIO_LSB = 8;
  localparam int ACD_REF_BIT = 7;

  // writable bits of the control word
  localparam logic [15:0] ACD_CTRL_MASK = 16'h3F80;

  // power-on values of the fields
  localparam logic ACD_SRC_RST = 1'b0;
  localparam logic [1:0] ACD_MODE_RST = 2'h0;
  localparam logic [2:0] ACD_RATIO_RST = 3'h0;
  localparam logic ACD_REF_RST = 1'b0;

  // oscillator mode codes
  localparam logic [1:0] ACD_MODE_OFF = 2'h0;
  localparam logic [1:0] ACD_MODE_HS = 2'h1;
  localparam logic [1:0] ACD_MODE_XT = 2'h2;
  localparam logic [1:0] ACD_MODE_EC = 2'h3;

  // status field positions
  localparam int ACD_ST_RUN_BIT = 0;
  localparam int ACD_ST_SRC_BIT = 1;
  localparam int ACD_ST_CNT_LSB = 8;

  // ratio code to terminal count (divide value minus one)
  function automatic logic [7:0] acd_limit(input logic [2:0] code);
    logic [7:0] lim;
    lim = 8'hFF;
    case (code)
      3'h7: lim = 8'h00;
      3'h6: lim = 8'h01;
      3'h5: lim = 8'h03;
      3'h4: lim = 8'h07;
      3'h3: lim = 8'h0F;
      3'h2: lim = 8'h1F;
      3'h1: lim = 8'h3F;
      default: lim = 8'hFF;
    endcase
    return lim;
  endfunction : acd_limit

endpackage : acd_pkg

/* logic/acd_clk_if.sv */
`timescale 1ns/1ns
// carries settings and ticks between the source mux and the divider
interface acd_clk_if;
  logic src_sel; // 1 aux oscillator, 0 pll
  logic [1:0] osc_mode; // oscillator mode
  logic [2:0] ratio; // post-divide code
  logic sys_rst_b; // non power-on reset, active low
  logic aux_tick; // aux oscillator edge pulse
  logic pll_tick; // pll edge pulse
  logic sel_tick; // selected source pulse
  logic div_tick; // divided output pulse
  logic [7:0] div_cnt; // output pulse count

  modport mux (input src_sel, input osc_mode, input sys_rst_b, input aux_tick,
    input pll_tick, output sel_tick);
  modport div (input ratio, input sys_rst_b, input sel_tick, output div_tick,
    output div_cnt);
  modport ctl (output src_sel, output osc_mode, output ratio, output sys_rst_b,
    output aux_tick, output pll_tick, input sel_tick, input div_tick, input div_cnt);
endinterface : acd_clk_if

/* logic/acd_src_mux.sv */
`timescale 1ns/1ns
// picks the divider input pulse from the aux oscillator or the pll
module acd_src_mux (
  input wire logic clk_i,
  input wire logic rst_b_i,
  acd_clk_if.mux cif
);

  logic sel_tick_r; // registered selected pulse

  // aux ticks only pass while the oscillator is enabled
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_tick_r <= 1'b0;
    end else if (!cif.sys_rst_b) begin
      sel_tick_r <= 1'b0;
    end else if (cif.src_sel) begin
      sel_tick_r <= cif.aux_tick && (cif.osc_mode != acd_pkg::ACD_MODE_OFF);
    end else begin
      sel_tick_r <= cif.pll_tick;
    end
  end

  assign cif.sel_tick = sel_tick_r;

  // aux source with oscillator off never yields a pulse
  AST_OSC_OFF_SILENT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cif.src_sel && cif.osc_mode == acd_pkg::ACD_MODE_OFF) |=> !sel_tick_r)
    else $error("aux pulse passed with oscillator off");

endmodule : acd_src_mux

/* logic/acd_post_div.sv */
`timescale 1ns/1ns
// divides the selected pulse train by the programmed ratio
module acd_post_div (
  input wire logic clk_i,
  input wire logic rst_b_i,
  acd_clk_if.div cif
);

  logic [7:0] cnt_r; // pulses since last output
  logic [7:0] cnt_nxt;
  logic div_tick_r; // divided pulse
  logic [7:0] out_cnt_r; // free running output count
  logic [7:0] lim; // terminal count for the ratio

  assign lim = acd_pkg::acd_limit(cif.ratio);

  // next input count, wraps at the terminal count
  always_comb begin
    cnt_nxt = cnt_r;
    if (cif.sel_tick) begin
      cnt_nxt = (cnt_r >= lim) ? 8'h00 : 8'(cnt_r + 8'h01);
    end
  end

  // counter and output pulse
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= 8'h00;
      div_tick_r <= 1'b0;
      out_cnt_r <= 8'h00;
    end else if (!cif.sys_rst_b) begin
      cnt_r <= 8'h00;
      div_tick_r <= 1'b0;
      out_cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
      div_tick_r <= cif.sel_tick && (cnt_r >= lim);
      if (cif.sel_tick && (cnt_r >= lim)) begin
        out_cnt_r <= 8'(out_cnt_r + 8'h01);
      end
    end
  end

  assign cif.div_tick = div_tick_r;
  assign cif.div_cnt = out_cnt_r;

  // divide by one passes every pulse
  AST_DIV_ONE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cif.sys_rst_b && cif.ratio == 3'h7 && cif.sel_tick) |=> div_tick_r)
    else $error("divide by one dropped a pulse");

  // output pulse only when terminal count was reached
  AST_DIV_TERM: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    div_tick_r |-> $past(cnt_r) >= $past(lim))
    else $error("divided pulse before terminal count");

endmodule : acd_post_div

/* dv/acd_tick_src.sv */
`timescale 1ns/1ns
// far side: emits a burst of oscillator or pll edge pulses
module acd_tick_src (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic to_aux_i,
  input wire logic [9:0] count_i,
  input wire logic [1:0] gap_i,
  output logic aux_tick_o,
  output logic pll_tick_o,
  output logic busy_o
);
  logic [9:0] left_r; // pulses still to send
  logic [1:0] wait_r; // idle cycles before next pulse
  logic aux_r; // burst goes to the aux line

  // burst engine, one-cycle pulses spaced by the gap
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      left_r <= 10'h000;
      wait_r <= 2'h0;
      aux_r <= 1'b0;
      aux_tick_o <= 1'b0;
      pll_tick_o <= 1'b0;
    end else if (start_i) begin
      left_r <= count_i;
      wait_r <= 2'h0;
      aux_r <= to_aux_i;
      aux_tick_o <= 1'b0;
      pll_tick_o <= 1'b0;
    end else begin
      aux_tick_o <= 1'b0;
      pll_tick_o <= 1'b0;
      if (left_r != 10'h000) begin
        if (wait_r == 2'h0) begin
          aux_tick_o <= aux_r;
          pll_tick_o <= !aux_r;
          left_r <= left_r - 10'h001;
          wait_r <= gap_i;
        end else begin
          wait_r <= wait_r - 2'h1;
        end
      end
    end
  end

  // busy while pulses remain
  assign busy_o = (left_r != 10'h000);
endmodule : acd_tick_src

/* dv/aux_clock_divider_control_tb.sv */
`timescale 1ns/1ns
// bench for the aux clock divider control block
module aux_clock_divider_control_tb;
  logic clk_i = 1'b0, rst_b = 1'b0, sys_rst_b = 1'b1; // clock and resets
  logic [31:0] paddr = 32'h0, pwdata = 32'h0; // apb request
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] prdata_o; // apb answer
  logic pready_o, pslverr_o;
  logic aux_t, pll_t, busy, start = 1'b0, to_aux = 1'b0; // partner link
  logic [9:0] cnt = 10'h0; // burst length
  logic [1:0] gap = 2'h0; // burst spacing
  logic [1:0] mode_o; // field outputs
  logic ref_o, src_o, div_o;
  logic [33:0] exp_q[$]; // {read, err, data}
  int n_errors = 0, num_checks = 0, n_div = 0;
  logic [31:0] v, base;
  localparam logic [31:0] CTRL = {20'h0, acd_pkg::ACD_CTRL_OFF};

  acd_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b), .sys_rst_b_i(sys_rst_b), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .pstrb_i(4'hF), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .aux_osc_tick_i(aux_t), .pll_tick_i(pll_t), .aux_oscillator_mode_o(mode_o),
    .aux_reference_source_select_o(ref_o), .aux_divider_source_select_o(src_o),
    .aux_div_tick_o(div_o));
  acd_tick_src i_src (.clk_i(clk_i), .rst_b_i(rst_b), .start_i(start), .to_aux_i(to_aux),
    .count_i(cnt), .gap_i(gap), .aux_tick_o(aux_t), .pll_tick_o(pll_t), .busy_o(busy));

  // 250 mhz clock
  initial forever #2 clk_i = ~clk_i;

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // verdict and stop
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // one apb transfer, expectation noted first
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      input logic err, input logic [31:0] exp);
    exp_q.push_back({!wr, err, exp});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    // wait for ready; only the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  // monitor pops the oldest note at each completed transfer
  always @(posedge clk_i) begin
    if (psel && penable && pready_o === 1'b1 && exp_q.size() > 0) begin
      logic [33:0] e;
      e = exp_q.pop_front();
      chk({31'h0, pslverr_o}, {31'h0, e[32]});
      if (e[33]) chk(prdata_o, e[31:0]);
    end
    if (div_o === 1'b1) n_div++;
  end

  // burst of n ticks after a divider clear, then count output pulses
  task automatic burst(input logic aux, input int n, input int exp);
    sys_rst_b <= 1'b0;
    @(posedge clk_i);
    sys_rst_b <= 1'b1;
    @(posedge clk_i);
    base = n_div;
    start <= 1'b1;
    to_aux <= aux;
    cnt <= n[9:0];
    gap <= 2'($urandom % 4);
    @(posedge clk_i);
    start <= 1'b0;
    repeat (2) @(posedge clk_i);
    while (busy === 1'b1) @(posedge clk_i);
    repeat (8) @(posedge clk_i);
    chk(n_div - base, exp);
  endtask : burst

  // watchdog
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    end_sim();
  end

  // main sequence
  initial begin
    void'($urandom(32'h4ab6));
    repeat (10) @(posedge clk_i);
    rst_b <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, CTRL, 32'h0, 1'b0, 32'h0);
    apb(1'b1, CTRL, 32'hFFFF, 1'b0, 32'h0);
    apb(1'b0, CTRL, 32'h0, 1'b0, 32'h3F80);
    chk({29'h0, src_o, mode_o}, 32'h7);
    chk({31'h0, ref_o}, 32'h1);
    // every oscillator mode with random other bits
    for (int m = 0; m < 4; m++) begin
      v = ($urandom & 32'hE7FF) | (m << 11);
      apb(1'b1, CTRL, v, 1'b0, 32'h0);
      apb(1'b0, CTRL, 32'h0, 1'b0, v & 32'h3F80);
      chk({28'h0, ref_o, src_o, mode_o}, {28'h0, v[7], v[13], v[12:11]});
    end
    // system reset keeps the register
    sys_rst_b <= 1'b0;
    repeat (2) @(posedge clk_i);
    sys_rst_b <= 1'b1;
    apb(1'b0, CTRL, 32'h0, 1'b0, v & 32'h3F80);
    // unmapped place and read-only status
    apb(1'b1, 32'h10, 32'hFFFF, 1'b1, 32'h0);
    apb(1'b0, 32'h10, 32'h0, 1'b1, 32'h0);
    apb(1'b1, {20'h0, acd_pkg::ACD_STAT_OFF}, 32'h0, 1'b0, 32'h0);
    apb(1'b0, CTRL, 32'h0, 1'b0, v & 32'h3F80);
    // every ratio on the pll path
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, CTRL, c << 8, 1'b0, 32'h0);
      burst(1'b0, 2 * ((c == 0) ? 256 : (1 << (7 - c))), 2);
    end
    // aux path: off blocks, ext clock passes, pll ignored
    apb(1'b1, CTRL, 32'h2600, 1'b0, 32'h0);
    burst(1'b1, 12, 0);
    // source aux, external clock mode, ratio code 110 divides by two
    apb(1'b1, CTRL, 32'h3E00, 1'b0, 32'h0);
    burst(1'b1, 12, 6);
    burst(1'b0, 12, 0);
    // status: oscillator running, aux source, no pulses since divider clear
    apb(1'b0, {20'h0, acd_pkg::ACD_STAT_OFF}, 32'h0, 1'b0, 32'h3);
    // power-on reset clears the register
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({29'h0, src_o, mode_o}, 32'h0);
    rst_b <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, CTRL, 32'h0, 1'b0, 32'h0);
    end_sim();
  end
endmodule : aux_clock_divider_control_tb
